// ### rtl/isv_pkg.sv
package isv_pkg;

	// sizes of the source and vector space
	localparam int IRQ_COUNT   = 63;           // irqs 0..62 handled here
	localparam int IRQ_W       = 6;            // irq number width
	localparam int VEC_W       = 6;            // vector number width
	localparam int PRIO_W      = 3;            // priority field width
	localparam int SUB_W       = 2;            // sub-priority field width
	localparam int WORD_W      = 32;           // flag, enable and priority word width
	localparam int FLAG_WORDS  = 2;            // flag and enable words
	localparam int PRIO_WORDS  = 13;           // priority words 0..12
	localparam int SLOT_BITS   = 8;            // bits per vector slot in a priority word
	localparam int SLOT_SEL_W  = 2;            // four slots per priority word
	localparam int PRIO_LSB    = 2;            // priority at slot bits 4:2
	localparam int SUB_LSB     = 0;            // sub-priority at slot bits 1:0
	localparam int EXT_PINS    = 5;            // external pin requests
	localparam int UNITS       = 5;            // timer/capture/compare units

	// irq numbers of each source or group of sources
	localparam int IRQ_CORE_TIMER = 0;         // core timer
	localparam int IRQ_CORE_SOFT  = 1;         // core software 0 and 1
	localparam int UNIT_STRIDE    = 4;         // unit k at 4k..4k+2, pin k at 4k+3
	localparam int OFS_CAPTURE    = 1;         // capture within a unit group
	localparam int OFS_COMPARE    = 2;         // compare within a unit group
	localparam int OFS_EXT_PIN    = 3;         // pin k-1 closes unit group k-1
	localparam int IRQ_SER1       = 23;        // serial port 1 fault/rx/tx
	localparam int IRQ_GROUP_A    = 26;        // shared uart1/spi3/i2c3
	localparam int IRQ_I2C1       = 29;        // i2c unit 1
	localparam int IRQ_CHANGE     = 32;        // input change
	localparam int IRQ_CONVERTER  = 33;        // converter done
	localparam int IRQ_PPORT      = 34;        // parallel port
	localparam int IRQ_COMPARATOR = 35;        // comparators 1 and 2
	localparam int IRQ_GROUP_B    = 37;        // shared uart2/spi2/i2c4
	localparam int IRQ_GROUP_C    = 40;        // shared uart3/spi4/i2c5
	localparam int IRQ_I2C2       = 43;        // i2c unit 2
	localparam int IRQ_CLK_MON    = 46;        // clock failure monitor
	localparam int IRQ_CALENDAR   = 47;        // calendar
	localparam int IRQ_DMA        = 48;        // dma channels 0..7
	localparam int IRQ_FLASH      = 56;        // flash event
	localparam int IRQ_USB        = 57;        // usb
	localparam int IRQ_CAN        = 58;        // can units 1 and 2
	localparam int IRQ_ETHERNET   = 60;        // ethernet
	localparam int IRQ_CAP_ERROR  = 61;        // capture 1 and 2 error

	// vector delivered in single-vector mode
	localparam logic [VEC_W-1:0] VEC_SINGLE = 6'h00;

	// vector of each irq, irq 0 first
	localparam logic [VEC_W-1:0] IRQ_VECTOR [0:IRQ_COUNT-1] = '{
		6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
		6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
		6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17,
		6'h17, 6'h17, 6'h18, 6'h18, 6'h18, 6'h19, 6'h19, 6'h19,
		6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h1F, 6'h1F,
		6'h20, 6'h20, 6'h20, 6'h21, 6'h21, 6'h21, 6'h22, 6'h23,
		6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2A, 6'h2B,
		6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h30, 6'h05, 6'h09
	};

	// three-event groups: [0] error/fault/collision, [1] rx/slave, [2] tx/master
	typedef struct packed {
		logic                 core_timer_request;    // core timer
		logic [1:0]           core_soft_request;     // core software 1..0
		logic [UNITS-1:0]     timer;                 // timer k at bit k-1
		logic [UNITS-1:0]     capture_unit;          // capture k at bit k-1
		logic [UNITS-1:0]     compare_unit;          // compare k at bit k-1
		logic [2:0]           serial_port1;          // spi unit 1
		logic [2:0]           uart1;                 // uart 1
		logic [2:0]           spi3;                  // spi 3
		logic [2:0]           i2c3;                  // i2c 3
		logic [2:0]           i2c1;                  // i2c 1
		logic                 input_change_request;  // input change
		logic                 converter_done;        // converter done
		logic                 parallel_port_request; // parallel port
		logic [1:0]           comparator_request;    // comparators 2..1
		logic [2:0]           uart2;                 // uart 2
		logic [2:0]           spi2;                  // spi 2
		logic [2:0]           i2c4;                  // i2c 4
		logic [2:0]           uart3;                 // uart 3
		logic [2:0]           spi4;                  // spi 4
		logic [2:0]           i2c5;                  // i2c 5
		logic [2:0]           i2c2;                  // i2c 2
		logic                 clock_failure_monitor; // clock monitor
		logic                 calendar_request;      // calendar
		logic [7:0]           dma_channel;           // dma 7..0
		logic                 flash_event;           // flash
		logic                 usb_request;           // usb
		logic [1:0]           can_request;           // can 2..1
		logic                 ethernet_request;      // ethernet
		logic [1:0]           capture_error;         // capture 2..1 error
	} isv_src_t;

	// request presented to the cpu
	typedef struct packed {
		logic                 valid;                 // a vector is requested
		logic [IRQ_W-1:0]     irq;                   // winning irq
		logic [VEC_W-1:0]     vector;                // vector to take
		logic [PRIO_W-1:0]    prio;                  // its priority
		logic [SUB_W-1:0]     sub;                   // its sub-priority
	} isv_req_t;

	// flag bank state
	typedef struct packed {
		logic [FLAG_WORDS*WORD_W-1:0] flags;         // all flag words
	} isv_bank_t;

	// controller state
	typedef struct packed {
		logic [EXT_PINS-1:0]  pin_meta;              // first sync stage
		logic [EXT_PINS-1:0]  pin_sync;              // second sync stage
		logic [EXT_PINS-1:0]  pin_prev;              // for edge detect
		isv_req_t             req;                   // registered request
	} isv_state_t;

endpackage

// ### rtl/isv_flag_bank.sv
`timescale 1ns/1ns
`default_nettype none

module isv_flag_bank #(
	parameter logic [isv_pkg::FLAG_WORDS*isv_pkg::WORD_W-1:0] PRESENT = '1  // implemented flags
) (
	input  wire logic                                              sys_clk_in,  // system clock
	input  wire logic                                              rst_n_in,    // synced reset, low
	input  wire logic [isv_pkg::FLAG_WORDS*isv_pkg::WORD_W-1:0]    set_in,      // hardware set pulses
	input  wire logic [isv_pkg::FLAG_WORDS-1:0]                    wr_en_in,    // software word write
	input  wire logic [isv_pkg::FLAG_WORDS*isv_pkg::WORD_W-1:0]    wr_data_in,  // software write data
	output logic      [isv_pkg::FLAG_WORDS*isv_pkg::WORD_W-1:0]    flags_out    // flag words
);

	isv_pkg::isv_bank_t state;       // registered flags
	isv_pkg::isv_bank_t next_state;  // next flags

	// per word: a write replaces the word, a hardware set always wins over a
	// clearing write in the same cycle so no event is lost
	always_comb begin
		next_state = state;
		for (int w = 0; w < isv_pkg::FLAG_WORDS; w++) begin
			if (wr_en_in[w]) begin
				next_state.flags[w*isv_pkg::WORD_W +: isv_pkg::WORD_W] =
					wr_data_in[w*isv_pkg::WORD_W +: isv_pkg::WORD_W];
			end
		end
		next_state.flags = next_state.flags | set_in;
		// absent sources never hold a flag
		next_state.flags = next_state.flags & PRESENT;
	end

	// flag register
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign flags_out = state.flags;

endmodule

`default_nettype wire

// ### rtl/isv_ctrl.sv
// Function
// - core timer irq 0, vector 0, word 0
// - flag/enable bit n%32 of word n/32
// - four vector slots per priority word
// - core software 0/1 at irqs 1, 2
// - unit k: timer, capture, compare; pin k at 4k+3
// - serial port 1 events 23-25 share vector 23
// - irqs 26-28 OR three peripherals, vector 24
// - i2c unit 1 irqs 29-31, vector 25
// - converter, parallel port, comparators own vectors
// - irqs 37-39 shared groups, vector 31
// - irqs 40-42 shared groups, vector 32
// - i2c unit 2 irqs 43-45, vector 33
// - clock monitor 46/34, calendar 47/35
// - dma channels 0-7 at irqs 48-55
// - flash, usb, can, ethernet fixed pairs
// - capture 1 error irq 61, vector 5
// - capture 2 error irq 62, vector 9
// - absent peripherals have no source
// - seven priorities, four sub-priorities each
// - single-vector and multi-vector delivery modes
// - software write sets any present flag
`timescale 1ns/1ns
`default_nettype none

module isv_ctrl #(
	parameter logic [isv_pkg::IRQ_COUNT-1:0] PRESENT_MASK = '1  // sources on this variant
) (
	input  wire logic                                                 sys_clk_in,         // 10 MHz clock
	input  wire logic                                                 reset_n_in,         // async reset, low
	input  wire isv_pkg::isv_src_t                                    src_in,             // source pulses
	input  wire logic [isv_pkg::EXT_PINS-1:0]                         ext_pin_request_in, // pin levels
	input  wire logic [isv_pkg::EXT_PINS-1:0]                         ext_pin_rising_in,  // 1 rising, 0 falling
	input  wire logic                                                 multi_vector_in,    // delivery mode
	input  wire logic [isv_pkg::FLAG_WORDS-1:0]                       flag_wr_en_in,      // flag word write
	input  wire logic [isv_pkg::FLAG_WORDS*isv_pkg::WORD_W-1:0]       flag_wr_data_in,    // flag write data
	input  wire logic [isv_pkg::WORD_W-1:0]                           enable_word_0_in,   // enables 31..0
	input  wire logic [isv_pkg::WORD_W-1:0]                           enable_word_1_in,   // enables 62..32
	input  wire logic [isv_pkg::PRIO_WORDS-1:0][isv_pkg::WORD_W-1:0]  priority_word_in,   // priority words
	output logic      [isv_pkg::WORD_W-1:0]                           flag_word_0_out,    // flags 31..0
	output logic      [isv_pkg::WORD_W-1:0]                           flag_word_1_out,    // flags 62..32
	output var isv_pkg::isv_req_t                                     cpu_req_out         // to the cpu
);

	localparam int FLAT_W = isv_pkg::FLAG_WORDS * isv_pkg::WORD_W;  // flat flag width

	// reset release synchroniser
	logic rst_meta;                      // first stage
	logic rst_n;                         // released reset used everywhere

	// state and flags
	isv_pkg::isv_state_t state;          // registered state
	isv_pkg::isv_state_t next_state;     // next state
	logic [FLAT_W-1:0]   events;         // hardware set pulses by irq
	logic [FLAT_W-1:0]   flags;          // flag words, flat
	logic [FLAT_W-1:0]   enables;        // enable words, flat
	logic [FLAT_W-1:0]   present;        // present mask, flat
	logic [isv_pkg::EXT_PINS-1:0] pin_edge;  // selected edge seen on a pin

	// best candidate of the arbiter
	logic                        best_valid;  // any candidate found
	logic [isv_pkg::IRQ_W-1:0]   best_irq;    // its irq
	logic [isv_pkg::VEC_W-1:0]   best_vec;    // its vector
	logic [isv_pkg::PRIO_W-1:0]  best_prio;   // its priority
	logic [isv_pkg::SUB_W-1:0]   best_sub;    // its sub-priority

	// priority and sub-priority of a vector: word vec/4, slot vec%4
	function automatic logic [isv_pkg::PRIO_W+isv_pkg::SUB_W-1:0] vec_fields(
		input logic [isv_pkg::VEC_W-1:0]                          vec,
		input logic [isv_pkg::PRIO_WORDS-1:0][isv_pkg::WORD_W-1:0] pw
	);
		logic [isv_pkg::WORD_W-1:0] word;     // selected priority word
		logic [isv_pkg::WORD_W-1:0] shifted;  // slot moved to the bottom
		word    = pw[vec[isv_pkg::VEC_W-1:isv_pkg::SLOT_SEL_W]];
		shifted = word >> (vec[isv_pkg::SLOT_SEL_W-1:0] * isv_pkg::SLOT_BITS);
		return {shifted[isv_pkg::PRIO_LSB +: isv_pkg::PRIO_W],
			shifted[isv_pkg::SUB_LSB +: isv_pkg::SUB_W]};
	endfunction

	// reset: asserted at once, released through two flops
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// pins are asynchronous: only the second stage and its delayed copy feed
	// the edge detector, the first stage feeds nothing but the second
	always_comb begin
		for (int k = 0; k < isv_pkg::EXT_PINS; k++) begin
			if (ext_pin_rising_in[k]) begin
				pin_edge[k] = state.pin_sync[k] & ~state.pin_prev[k];  // rising edge
			end else begin
				pin_edge[k] = ~state.pin_sync[k] & state.pin_prev[k];  // falling edge
			end
		end
	end

	// gather every source onto its irq number; shared irqs are an or of
	// their peripherals, so software must poll them to find the cause
	always_comb begin
		events = '0;
		events[isv_pkg::IRQ_CORE_TIMER] = src_in.core_timer_request;
		events[isv_pkg::IRQ_CORE_SOFT +: 2] = src_in.core_soft_request;
		for (int k = 0; k < isv_pkg::UNITS; k++) begin
			// unit k+1 fills irqs 4(k+1)..4(k+1)+2, pin k closes group k
			events[isv_pkg::UNIT_STRIDE*(k+1)] = src_in.timer[k];
			events[isv_pkg::UNIT_STRIDE*(k+1) + isv_pkg::OFS_CAPTURE] =
				src_in.capture_unit[k];
			events[isv_pkg::UNIT_STRIDE*(k+1) + isv_pkg::OFS_COMPARE] =
				src_in.compare_unit[k];
			events[isv_pkg::UNIT_STRIDE*k + isv_pkg::OFS_EXT_PIN] = pin_edge[k];
		end
		events[isv_pkg::IRQ_SER1 +: 3] = src_in.serial_port1;
		events[isv_pkg::IRQ_GROUP_A +: 3] = src_in.uart1 | src_in.spi3 | src_in.i2c3;
		events[isv_pkg::IRQ_I2C1 +: 3] = src_in.i2c1;
		events[isv_pkg::IRQ_CHANGE] = src_in.input_change_request;
		events[isv_pkg::IRQ_CONVERTER] = src_in.converter_done;
		events[isv_pkg::IRQ_PPORT] = src_in.parallel_port_request;
		events[isv_pkg::IRQ_COMPARATOR +: 2] = src_in.comparator_request;
		events[isv_pkg::IRQ_GROUP_B +: 3] = src_in.uart2 | src_in.spi2 | src_in.i2c4;
		events[isv_pkg::IRQ_GROUP_C +: 3] = src_in.uart3 | src_in.spi4 | src_in.i2c5;
		events[isv_pkg::IRQ_I2C2 +: 3] = src_in.i2c2;
		events[isv_pkg::IRQ_CLK_MON] = src_in.clock_failure_monitor;
		events[isv_pkg::IRQ_CALENDAR] = src_in.calendar_request;
		events[isv_pkg::IRQ_DMA +: 8] = src_in.dma_channel;
		events[isv_pkg::IRQ_FLASH] = src_in.flash_event;
		events[isv_pkg::IRQ_USB] = src_in.usb_request;
		events[isv_pkg::IRQ_CAN +: 2] = src_in.can_request;
		events[isv_pkg::IRQ_ETHERNET] = src_in.ethernet_request;
		events[isv_pkg::IRQ_CAP_ERROR +: 2] = src_in.capture_error;
	end

	// bit n of the flat vectors is bit n%32 of word n/32
	assign enables = {enable_word_1_in, enable_word_0_in};
	assign present = {1'b0, PRESENT_MASK};

	// flag words with hardware set and software write; the mask must be a
	// constant expression here, a net cannot feed a parameter
	isv_flag_bank #(
		.PRESENT    ({1'b0, PRESENT_MASK})
	) isv_flag_bank_inst (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n),
		.set_in     (events),
		.wr_en_in   (flag_wr_en_in),
		.wr_data_in (flag_wr_data_in),
		.flags_out  (flags)
	);

	assign flag_word_0_out = flags[0 +: isv_pkg::WORD_W];
	assign flag_word_1_out = flags[isv_pkg::WORD_W +: isv_pkg::WORD_W];

	// arbiter: highest priority, then highest sub-priority, then lowest irq;
	// walking down from the top with >= lets a lower irq take a tie
	always_comb begin
		logic [isv_pkg::VEC_W-1:0]               vec;     // vector of irq i
		logic [isv_pkg::PRIO_W+isv_pkg::SUB_W-1:0] fld;   // its fields
		vec        = '0;
		fld        = '0;
		best_valid = 1'b0;
		best_irq   = '0;
		best_vec   = '0;
		best_prio  = '0;
		best_sub   = '0;
		for (int i = isv_pkg::IRQ_COUNT - 1; i >= 0; i--) begin
			vec = isv_pkg::IRQ_VECTOR[i];
			fld = vec_fields(vec, priority_word_in);
			// priority zero disables the vector
			if (flags[i] && enables[i] && present[i] &&
				fld[isv_pkg::SUB_W +: isv_pkg::PRIO_W] != '0) begin
				if (!best_valid || fld >= {best_prio, best_sub}) begin
					best_valid = 1'b1;
					best_irq   = isv_pkg::IRQ_W'(i);
					best_vec   = vec;
					best_prio  = fld[isv_pkg::SUB_W +: isv_pkg::PRIO_W];
					best_sub   = fld[isv_pkg::SUB_W-1:0];
				end
			end
		end
	end

	// next state: pin pipeline and the registered cpu request
	always_comb begin
		next_state          = state;
		next_state.pin_meta = ext_pin_request_in;
		next_state.pin_sync = state.pin_meta;
		next_state.pin_prev = state.pin_sync;
		next_state.req.valid = best_valid;
		next_state.req.irq   = best_irq;
		next_state.req.prio  = best_prio;
		next_state.req.sub   = best_sub;
		if (multi_vector_in) begin
			// each vector has its own entry point
			next_state.req.vector = best_vec;
		end else begin
			// every request enters through one common vector
			next_state.req.vector = isv_pkg::VEC_SINGLE;
		end
	end

	// state register; pin stages reset low, so a pin held high at release
	// reads as a rising edge two cycles later, a known start-up hazard
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// request straight from flops
	assign cpu_req_out = state.req;

endmodule

`default_nettype wire

// ### testbench/isv_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none

module isv_ctrl_props #(
	parameter logic [62:0] PRESENT_MASK = '1 // sources on this variant
) (
	input wire logic              sys_clk_in,         // clock
	input wire logic              reset_n_in,         // async reset, low
	input wire isv_pkg::isv_src_t src_in,             // source pulses
	input wire logic [4:0]        ext_pin_request_in, // pin levels
	input wire logic [4:0]        ext_pin_rising_in,  // pin polarity
	input wire logic              multi_vector_in,    // delivery mode
	input wire logic [1:0]        flag_wr_en_in,      // flag word write
	input wire logic [63:0]       flag_wr_data_in,    // flag write data
	input wire logic [31:0]       enable_word_0_in,   // enables low
	input wire logic [31:0]       enable_word_1_in,   // enables high
	input wire logic [12:0][31:0] priority_word_in,   // priority words
	input wire logic [31:0]       flag_word_0_out,    // flags low
	input wire logic [31:0]       flag_word_1_out,    // flags high
	input wire isv_pkg::isv_req_t cpu_req_out         // request
);
	logic [63:0]       flags_q; // flags the arbiter saw last edge
	logic [63:0]       ens_q;   // enables the arbiter saw last edge
	logic [12:0][31:0] pw_q;    // priorities the arbiter saw last edge
	logic [5:0]        v;       // presented vector
	logic              ok;      // request valid shorthand

	assign v = cpu_req_out.vector;
	assign ok = cpu_req_out.valid;

	// one-edge copies, since the request is registered from them
	always_ff @(posedge sys_clk_in) begin
		flags_q <= {flag_word_1_out, flag_word_0_out};
		ens_q <= {enable_word_1_in, enable_word_0_in};
		pw_q <= priority_word_in;
	end

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);

	AST_WINNER_FLAGGED: assert property (ok |-> flags_q[cpu_req_out.irq] && ens_q[cpu_req_out.irq])
		else $error("request for an irq not flagged and enabled");
	AST_PRIO_NONZERO: assert property (ok |-> cpu_req_out.prio != 3'h0)
		else $error("request with priority zero");
	AST_PRIO_FIELD: assert property (ok && $past(multi_vector_in) |->
		cpu_req_out.prio == pw_q[v[5:2]][{v[1:0], 3'h2} +: 3]
		&& cpu_req_out.sub == pw_q[v[5:2]][{v[1:0], 3'h0} +: 2]) else $error("priority fields of wrong slot");
	AST_SINGLE_VEC: assert property (ok && !$past(multi_vector_in) |-> v == 6'h00)
		else $error("single mode vector not zero");
	AST_LOW_VEC: assert property (ok && $past(multi_vector_in) && cpu_req_out.irq <= 6'h16 |-> v == cpu_req_out.irq)
		else $error("low irq vector mismatch");
	AST_SHARED_VEC: assert property (ok && $past(multi_vector_in) && cpu_req_out.irq inside {[6'h17:6'h19]} |-> v == 6'h17)
		else $error("serial port 1 vector mismatch");
	AST_CAPERR_VEC: assert property (ok && $past(multi_vector_in) && cpu_req_out.irq >= 6'h3D
		|-> v == (cpu_req_out.irq[0] ? 6'h05 : 6'h09)) else $error("capture error vector mismatch");
	AST_SOFT_WRITE: assert property (flag_wr_en_in[1] && src_in == '0
		|=> flag_word_1_out == ($past(flag_wr_data_in[63:32]) & {1'b0, PRESENT_MASK[62:32]}))
		else $error("flag word write not taken");
	AST_ABSENT: assert property (({flag_word_1_out, flag_word_0_out} & ~{1'b0, PRESENT_MASK}) == 64'h0)
		else $error("absent irq flagged");

	COV_CAPERR: cover property (ok && cpu_req_out.irq == 6'h3D);
	COV_SINGLE: cover property (ok && !multi_vector_in);
	COV_WRITE: cover property (flag_wr_en_in[1]);
endmodule

bind isv_ctrl isv_ctrl_props #(.PRESENT_MASK(PRESENT_MASK)) isv_ctrl_props_inst (
	.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .src_in(src_in), .ext_pin_request_in(ext_pin_request_in),
	.ext_pin_rising_in(ext_pin_rising_in), .multi_vector_in(multi_vector_in), .flag_wr_en_in(flag_wr_en_in),
	.flag_wr_data_in(flag_wr_data_in), .enable_word_0_in(enable_word_0_in), .enable_word_1_in(enable_word_1_in),
	.priority_word_in(priority_word_in), .flag_word_0_out(flag_word_0_out), .flag_word_1_out(flag_word_1_out),
	.cpu_req_out(cpu_req_out));

`default_nettype wire

// ### testbench/isv_src_model.sv
`timescale 1ns/1ns
`default_nettype none

module isv_src_model (
	input  wire logic            sys_clk_in, // clock
	input  wire logic            go_in,      // fire selected source
	input  wire logic [4:0]      sel_in,     // source select
	output var isv_pkg::isv_src_t src_out,   // one-cycle events
	output logic [4:0]           pin_out     // pin levels
);
	logic [3:0] pin_hold = 4'h0; // stretch so the synchroniser cannot miss it

	always_ff @(posedge sys_clk_in) pin_hold <= {pin_hold[2:0], go_in && sel_in == 5'h16};
	assign pin_out = {4'h0, |pin_hold};

	// peripherals pulse for exactly the cycle that go is high
	always_comb begin
		src_out = '0;
		if (go_in) begin
			case (sel_in)
				5'h00: src_out.core_timer_request = 1'b1;
				5'h01: src_out.core_soft_request[1] = 1'b1;
				5'h02: src_out.timer[2] = 1'b1;
				5'h03: src_out.capture_unit[0] = 1'b1;
				5'h04: src_out.compare_unit[4] = 1'b1;
				5'h05: src_out.serial_port1[1] = 1'b1;
				5'h06: src_out.spi3[0] = 1'b1;
				5'h07: src_out.i2c1[2] = 1'b1;
				5'h08: src_out.input_change_request = 1'b1;
				5'h09: src_out.converter_done = 1'b1;
				5'h0A: src_out.comparator_request[1] = 1'b1;
				5'h0B: src_out.i2c4[1] = 1'b1;
				5'h0C: src_out.spi4[2] = 1'b1;
				5'h0D: src_out.i2c2[0] = 1'b1;
				5'h0E: src_out.clock_failure_monitor = 1'b1;
				5'h0F: src_out.calendar_request = 1'b1;
				5'h10: src_out.dma_channel[7] = 1'b1;
				5'h11: src_out.can_request[1] = 1'b1;
				5'h12: src_out.ethernet_request = 1'b1;
				5'h13: src_out.capture_error[0] = 1'b1;
				5'h14: src_out.capture_error[1] = 1'b1;
				5'h15: src_out.flash_event = 1'b1;
				5'h17: src_out.usb_request = 1'b1;
				default: ;
			endcase
		end
	end
endmodule

`default_nettype wire

// ### testbench/isv_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none

module isv_ctrl_tb;
	localparam logic [62:0] MASK = ~(63'h1 << 57); // usb absent here
	logic              clk = 1'b0;     // bench clock
	logic              rst_n = 1'b0;   // bench reset
	logic              go = 1'b0;      // fire a source
	logic [4:0]        sel = 5'h00;    // source select
	logic [4:0]        pol = 5'h1F;    // pin edge polarity, 1 rising
	logic              mv = 1'b1;      // multi-vector mode
	logic [1:0]        wr_en = 2'h0;   // flag write strobes
	logic [63:0]       wr_data = '0;   // flag write data
	logic [63:0]       en = '1;        // enables
	logic [12:0][31:0] pw = '0;        // priority words
	isv_pkg::isv_src_t src;            // source events
	logic [4:0]        pins;           // pin levels
	logic [31:0]       f0;             // flags low
	logic [31:0]       f1;             // flags high
	isv_pkg::isv_req_t req;            // request
	isv_pkg::isv_req_t prev = '0;      // request at last edge
	isv_pkg::isv_req_t expq[$];        // expected requests
	int                errors = 0;     // mismatches
	int                check_count = 0; // comparisons
	logic [5:0] exp_irq [23] = '{6'h00, 6'h02, 6'h0C, 6'h05, 6'h16, 6'h18, 6'h1A, 6'h1F, 6'h20, 6'h21, 6'h24, 6'h26,
		6'h2A, 6'h2B, 6'h2E, 6'h2F, 6'h37, 6'h3B, 6'h3C, 6'h3D, 6'h3E, 6'h38, 6'h03};
	logic [5:0] exp_vec [23] = '{6'h00, 6'h02, 6'h0C, 6'h05, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1E, 6'h1F,
		6'h20, 6'h21, 6'h22, 6'h23, 6'h2B, 6'h2F, 6'h30, 6'h05, 6'h09, 6'h2C, 6'h03};

	isv_ctrl #(.PRESENT_MASK(MASK)) isv_ctrl_inst (.sys_clk_in(clk), .reset_n_in(rst_n), .src_in(src),
		.ext_pin_request_in(pins), .ext_pin_rising_in(pol), .multi_vector_in(mv), .flag_wr_en_in(wr_en),
		.flag_wr_data_in(wr_data), .enable_word_0_in(en[31:0]), .enable_word_1_in(en[63:32]),
		.priority_word_in(pw), .flag_word_0_out(f0), .flag_word_1_out(f1), .cpu_req_out(req));
	isv_src_model isv_src_model_inst (.sys_clk_in(clk), .go_in(go), .sel_in(sel), .src_out(src), .pin_out(pins));

	always #50 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		check_count++;
		if (seen !== expv) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, expv);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask

	// a software write of zero wipes both flag words
	task automatic clear_flags();
		@(posedge clk);
		wr_en <= 2'h3;
		wr_data <= '0;
		@(posedge clk);
		wr_en <= 2'h0;
		cycles(3);
	endtask

	// each new request shown to the cpu is matched with the oldest note
	always @(posedge clk) begin
		if (req.valid === 1'b1 && req !== prev) begin
			if (expq.size() == 0) check(32'(req), 32'h0);
			else check(32'(req), 32'(expq.pop_front()));
		end
		prev <= req;
	end

	initial begin
		logic [2:0] p;
		logic [1:0] s;
		void'($urandom(15));
		cycles(6);
		rst_n <= 1'b1;
		cycles(4);
		// one source at a time, with random equal settings everywhere
		for (int i = 0; i < 23; i++) begin
			p = 3'(32'h1 + $urandom % 32'h7);
			s = 2'($urandom);
			pw <= {52{3'h0, p, s}};
			sel <= 5'(i);
			go <= 1'b1;
			expq.push_back({1'b1, exp_irq[i], exp_vec[i], p, s});
			@(posedge clk);
			go <= 1'b0;
			cycles(8);
			check(32'({f1, f0} >> exp_irq[i]) & 32'h1, 32'h1);
			clear_flags();
		end
		// absent source never flags nor requests
		sel <= 5'h17;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		cycles(4);
		check({31'h0, f1[25]}, 32'h0);
		check({31'h0, req.valid}, 32'h0);
		// software raises irqs 40 and 62 with equal settings
		pw <= {52{8'h0D}};
		wr_en <= 2'h2;
		wr_data <= {32'h4000_0100, 32'h0};
		expq.push_back({1'b1, 6'h28, 6'h20, 3'h3, 2'h1});
		@(posedge clk);
		wr_en <= 2'h0;
		cycles(3);
		pw[2][9:8] <= 2'h3;
		expq.push_back({1'b1, 6'h3E, 6'h09, 3'h3, 2'h3});
		cycles(3);
		pw[8][4:2] <= 3'h7;
		expq.push_back({1'b1, 6'h28, 6'h20, 3'h7, 2'h1});
		cycles(3);
		mv <= 1'b0;
		expq.push_back({1'b1, 6'h28, 6'h00, 3'h7, 2'h1});
		cycles(3);
		en <= '0;
		cycles(3);
		check({31'h0, req.valid}, 32'h0);
		mv <= 1'b1;
		en <= '1;
		expq.push_back({1'b1, 6'h28, 6'h20, 3'h7, 2'h1});
		cycles(4);
		// falling polarity: only the trailing edge of the pin pulse may flag
		clear_flags();
		pol <= 5'h1E;
		sel <= 5'h16;
		go <= 1'b1;
		expq.push_back({1'b1, 6'h03, 6'h03, 3'h3, 2'h1});
		@(posedge clk);
		go <= 1'b0;
		cycles(5);
		check({31'h0, f0[3]}, 32'h0);
		cycles(6);
		check({31'h0, f0[3]}, 32'h1);
		check(32'(expq.size()), 32'h0);
		give_verdict();
	end

	// cut a hang short well past the expected run length
	initial begin
		#1000000;
		errors++;
		give_verdict();
	end
endmodule

`default_nettype wire
